// *** shared/gdrv_pkg.sv ***
package gdrv_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int REF_CLK_MHZ = 40; // Logic clock rate
    localparam int INPUT_FILTER_NS = 40; // Deglitch width on the PWM pins
    localparam int RUN_FILTER_NS = 40; // Deglitch width on the run/enable pin
    localparam int SUPPLY_FILTER_NS = 1000; // Supply comparator deglitch width
    // Least times round up to whole cycles
    localparam int INPUT_FILTER_CYC = (INPUT_FILTER_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int RUN_FILTER_CYC = (RUN_FILTER_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int SUPPLY_FILTER_CYC = (SUPPLY_FILTER_NS * REF_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Filter channels
    // ------------------------------------------------------------
    localparam int CH_COUNT = 6; // Number of filtered inputs
    localparam int CH_IN_POS = 0; // Non-inverting PWM input
    localparam int CH_IN_NEG = 1; // Inverting PWM input
    localparam int CH_RUN = 2; // Run/enable input
    localparam int CH_VCC_TRIP = 3; // Input-side supply below threshold
    localparam int CH_VDD_TRIP = 4; // Output-side supply below 12 V
    localparam int CH_VDD_REL = 5; // Output-side supply above 12 V plus 800 mV
    localparam int CNT_W = 8; // Filter counter width

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CH_COUNT-1:0] FILT_RST = 6'h18; // Inputs low, supplies locked
    localparam logic LOCK_RST = 1'b1; // Lockout holds from reset

    // Filter length in cycles for one channel
    function automatic logic [CNT_W-1:0] gdrv_filt_len(input int ch);
        if (ch == CH_RUN) begin
            return CNT_W'(RUN_FILTER_CYC);
        end else if (ch >= CH_VCC_TRIP) begin
            return CNT_W'(SUPPLY_FILTER_CYC);
        end
        return CNT_W'(INPUT_FILTER_CYC);
    endfunction : gdrv_filt_len
endpackage : gdrv_pkg

// *** logic/gdrv_gate_ctrl.sv ***
`timescale 1ns/100ps
// Summary of operation
// (R1) Deglitch both PWM inputs and run pin
// (R2) Pulses shorter than filter never reach gate
// (R3) Floating inputs keep gate output low
// (R4) Either supply locked out forces gate low
// (R5) Gate high only after both supplies good
// (R6) Output supply trips 12 V, 800 mV hysteresis
// (R7) Supply lockout detection is deglitched too
// (R8) Supply-good flag pulled low during lockout
// (R9) Lockout stops sense conversion, output low
// (R10) Host pulls supply-good flag up externally
// (R11) Run pin low past filter disables driver
// (R12) Run pin defaults disabled, host drives high
// (R13) Gate high needs pos high, neg low, enabled
module gdrv_gate_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic in_pos,
    input wire logic in_neg,
    input wire logic run_enable,
    input wire logic vcc_below_trip,
    input wire logic vdd_below_trip,
    input wire logic vdd_above_release,
    input wire logic sense_pwm_raw,
    output logic gate_drive_output,
    output logic supply_good_out,
    output logic supply_good_oe,
    output logic isolated_sense_pwm_output,
    output logic sense_convert_enable
);
    import gdrv_pkg::*;

    // ------------------------------------------------------------
    // Synchronisers and deglitch filters
    // ------------------------------------------------------------
    logic [CH_COUNT-1:0] raw_in; // Pin levels gathered by channel
    logic [2:0] sync_q [CH_COUNT]; // Three-stage synchronisers
    logic [CNT_W-1:0] filt_cnt [CH_COUNT]; // Stable-time counters
    logic [CH_COUNT-1:0] filt; // Filtered levels
    logic [2:0] sense_sync; // Synchroniser for the sense pulse train
    logic vcc_lock; // Input-side supply in lockout
    logic vdd_lock; // Output-side supply in lockout
    logic lockout; // Any supply lockout
    logic next_gate; // Gate level for the next cycle

    // Gather the pins in channel order
    assign raw_in = {vdd_above_release, vdd_below_trip, vcc_below_trip,
                     run_enable, in_neg, in_pos};

    // Shift each pin through three flip-flops
    always_ff @(posedge ref_clk) begin
        for (int ch = 0; ch < CH_COUNT; ch++) begin
            if (reset) begin
                sync_q[ch] <= {3{FILT_RST[ch]}};
            end else begin
                sync_q[ch] <= {sync_q[ch][1:0], raw_in[ch]};
            end
        end
    end

    // Accept a new level only after it agrees for the whole filter length
    always_ff @(posedge ref_clk) begin
        for (int ch = 0; ch < CH_COUNT; ch++) begin
            if (reset) begin
                filt[ch] <= FILT_RST[ch]; // R3 R12
                filt_cnt[ch] <= '0;
            end else if (sync_q[ch][1] == sync_q[ch][2] && sync_q[ch][2] != filt[ch]) begin
                // Candidate differs and stages agree: count stable time
                if (filt_cnt[ch] == gdrv_filt_len(ch) - CNT_W'(1)) begin
                    filt[ch] <= sync_q[ch][2]; // R1 R2 R7
                    filt_cnt[ch] <= '0;
                end else begin
                    filt_cnt[ch] <= filt_cnt[ch] + CNT_W'(1);
                end
            end else begin
                // Glitch or no change: restart the count
                filt_cnt[ch] <= '0; // R2
            end
        end
    end

    // ------------------------------------------------------------
    // Supply lockout
    // ------------------------------------------------------------
    // Input-side lockout follows its filtered comparator
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vcc_lock <= LOCK_RST;
        end else begin
            vcc_lock <= filt[CH_VCC_TRIP]; // R4 R7
        end
    end

    // Output-side lockout trips at 12 V and releases only above the hysteresis band
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vdd_lock <= LOCK_RST;
        end else if (filt[CH_VDD_TRIP]) begin
            vdd_lock <= 1'b1; // R6
        end else if (filt[CH_VDD_REL]) begin
            vdd_lock <= 1'b0; // R6
        end
    end

    // Either supply in lockout holds the gate off
    assign lockout = vcc_lock | vdd_lock;

    // ------------------------------------------------------------
    // Gate drive
    // ------------------------------------------------------------
    // High only with pos high, neg low, run enabled and no lockout
    always_comb begin
        next_gate = filt[CH_IN_POS] & ~filt[CH_IN_NEG]; // R13 R3
        if (!filt[CH_RUN]) begin
            next_gate = 1'b0; // R11 R12
        end
        if (lockout) begin
            next_gate = 1'b0; // R4 R5
        end
    end

    // Register the gate level
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gate_drive_output <= 1'b0; // R3
        end else begin
            gate_drive_output <= next_gate;
        end
    end

    // ------------------------------------------------------------
    // Supply-good flag and sense output
    // ------------------------------------------------------------
    // Open-drain flag: drive low during lockout, release otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            supply_good_out <= 1'b0;
            supply_good_oe <= 1'b1;
        end else begin
            supply_good_out <= 1'b0;
            supply_good_oe <= lockout; // R8 R10
        end
    end

    // Sense pulse train sync
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sense_sync <= 3'h0;
        end else begin
            sense_sync <= {sense_sync[1:0], sense_pwm_raw};
        end
    end

    // Conversion runs and output follows only outside lockout
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sense_convert_enable <= 1'b0;
            isolated_sense_pwm_output <= 1'b0;
        end else begin
            sense_convert_enable <= ~lockout; // R9
            if (lockout) begin
                isolated_sense_pwm_output <= 1'b0; // R9
            end else if (sense_sync[1] == sense_sync[2]) begin
                isolated_sense_pwm_output <= sense_sync[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Gate gating by lockout and input levels
    AST_LOCK_GATE_LOW: assert property (lockout |=> !gate_drive_output) // R4
        else $error("Gate high during supply lockout");
    AST_GATE_CAUSE: assert property (gate_drive_output |-> // R13
        $past(filt[CH_IN_POS] && !filt[CH_IN_NEG] && filt[CH_RUN]))
        else $error("Gate high without valid inputs");
    // Pin filters pass only levels that stood long enough
    AST_POS_STABLE: assert property ($changed(filt[CH_IN_POS]) |-> // R2
        $past(sync_q[CH_IN_POS][2]) == filt[CH_IN_POS]
        && $past(sync_q[CH_IN_POS][2], 2) == filt[CH_IN_POS])
        else $error("Positive input passed a short pulse");
    AST_NEG_STABLE: assert property ($changed(filt[CH_IN_NEG]) |-> // R2
        $past(sync_q[CH_IN_NEG][2]) == filt[CH_IN_NEG]
        && $past(sync_q[CH_IN_NEG][2], 2) == filt[CH_IN_NEG])
        else $error("Inverting input passed a short pulse");
    AST_RUN_FILTER: assert property ($changed(filt[CH_RUN]) |-> // R1
        $past(filt_cnt[CH_RUN]) == CNT_W'(RUN_FILTER_CYC - 1))
        else $error("Run input changed before filter time");
    AST_RUN_OFF: assert property (!filt[CH_RUN] |=> !gate_drive_output) // R11
        else $error("Gate high while run disabled");
    AST_FLAG: assert property (lockout |=> supply_good_oe && !supply_good_out) // R8
        else $error("Supply-good flag not pulled low in lockout");
    AST_FLAG_REL: assert property (!lockout |=> !supply_good_oe) // R8
        else $error("Supply-good flag held without lockout");
    AST_SENSE: assert property (lockout |=> !isolated_sense_pwm_output // R9
        && !sense_convert_enable)
        else $error("Sense output active during lockout");
    AST_CONV_RUN: assert property (!lockout |=> sense_convert_enable) // R9
        else $error("Sense conversion stopped without lockout");
    // Supply lockout filtering and hysteresis
    AST_HYST: assert property ($fell(vdd_lock) |-> // R6
        $past(filt[CH_VDD_REL]) && !$past(filt[CH_VDD_TRIP]))
        else $error("Output supply released without hysteresis");
    AST_SUP_FILT: assert property ($rose(filt[CH_VDD_TRIP]) |-> // R7
        $past(filt_cnt[CH_VDD_TRIP]) == CNT_W'(SUPPLY_FILTER_CYC - 1))
        else $error("Supply trip not deglitched");
    AST_BOTH_GOOD: assert property ($rose(gate_drive_output) |-> // R5
        !$past(vcc_lock) && !$past(vdd_lock))
        else $error("Gate rose with a supply locked");

    // Coverage of the main scenarios
    COV_GATE_ON: cover property ($rose(gate_drive_output));
    COV_SENSE_RUN: cover property (!lockout ##1 $rose(isolated_sense_pwm_output));
    COV_LOCKOUT: cover property ($rose(lockout) ##1 !gate_drive_output);
    COV_GLITCH: cover property (!filt[CH_IN_POS] && sync_q[CH_IN_POS][2]
        ##1 !sync_q[CH_IN_POS][2] && !filt[CH_IN_POS]);
    COV_RELEASE: cover property ($fell(vdd_lock));
endmodule : gdrv_gate_ctrl

// *** verification/gdrv_host_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host controller model
// ------------------------------------------------------------
module gdrv_host_model (
    input wire logic ref_clk,
    output logic in_pos,
    output logic in_neg,
    output logic run_enable,
    output logic sense_pwm_raw
);
    int phase; // Divider for the sense pulse train
    // Pins start driven low by the model, so they read low
    initial begin
        in_pos = 1'b0;
        in_neg = 1'b0;
        run_enable = 1'b0;
        sense_pwm_raw = 1'b0;
        phase = 0;
    end
    // Free-running sense train, eight cycles a period
    always begin
        @(posedge ref_clk);
        #2;
        phase++;
        sense_pwm_raw = phase[2];
    end
    // Drive the control pins just after an edge; run high enables the driver
    task automatic set_pins(input logic pos, input logic neg, input logic run);
        @(posedge ref_clk);
        #2;
        in_pos = pos;
        in_neg = neg;
        run_enable = run;
    endtask : set_pins
endmodule : gdrv_host_model

// *** verification/gate_driver_input_supply_lockout_gating_tb_top.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Testbench top
// ------------------------------------------------------------
module gate_driver_input_supply_lockout_gating_tb_top;
    logic ref_clk, reset, in_pos, in_neg, run_enable, sense_pwm_raw;
    logic vcc_below_trip, vdd_below_trip, vdd_above_release;
    logic gate_drive_output, supply_good_out, supply_good_oe;
    logic isolated_sense_pwm_output, sense_convert_enable;
    logic supply_good_wire; // Flag level seen by the host
    int num_errors = 0;
    int checks_done = 0;
    // External pull-up on the open-drain flag
    assign supply_good_wire = supply_good_oe ? supply_good_out : 1'b1;
    gdrv_gate_ctrl gdrv_gate_ctrl_inst (.ref_clk(ref_clk), .reset(reset), .in_pos(in_pos),
        .in_neg(in_neg), .run_enable(run_enable), .vcc_below_trip(vcc_below_trip),
        .vdd_below_trip(vdd_below_trip), .vdd_above_release(vdd_above_release),
        .sense_pwm_raw(sense_pwm_raw), .gate_drive_output(gate_drive_output),
        .supply_good_out(supply_good_out), .supply_good_oe(supply_good_oe),
        .isolated_sense_pwm_output(isolated_sense_pwm_output),
        .sense_convert_enable(sense_convert_enable));
    gdrv_host_model gdrv_host_model_inst (.ref_clk(ref_clk), .in_pos(in_pos), .in_neg(in_neg),
        .run_enable(run_enable), .sense_pwm_raw(sense_pwm_raw));
    // Clock generator, 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Compare one bit and count it
    task automatic check(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    // Advance n cycles, landing just after the edge
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #2;
        end
    endtask : cyc
    // Wait a bounded time for the gate level; a timeout ends the run
    task automatic expect_gate(input logic exp, input int bound);
        for (int i = 0; i < bound && gate_drive_output !== exp; i++) cyc(1);
        check("gate_drive_output", exp, gate_drive_output);
        if (gate_drive_output !== exp) summarize();
    endtask : expect_gate
    // Gate must stay at one level every cycle
    task automatic hold_gate(input logic exp, input int n);
        repeat (n) begin
            cyc(1);
            check("gate_drive_output", exp, gate_drive_output);
        end
    endtask : hold_gate
    // Watch the sense output for two train periods: silent in lockout, toggling otherwise
    task automatic check_sense(input logic locked);
        logic seen_hi;
        logic seen_lo;
        seen_hi = 1'b0;
        seen_lo = 1'b0;
        repeat (16) begin
            cyc(1);
            seen_hi |= (isolated_sense_pwm_output === 1'b1);
            seen_lo |= (isolated_sense_pwm_output === 1'b0);
        end
        check("isolated_sense_pwm_output high", !locked, seen_hi);
        check("isolated_sense_pwm_output low", 1'b1, seen_lo);
    endtask : check_sense
    // Lockout outputs all at once
    task automatic check_lock(input logic locked);
        check("supply_good_wire", !locked, supply_good_wire);
        check("sense_convert_enable", !locked, sense_convert_enable);
        check_sense(locked);
    endtask : check_lock
    // Power up: gate waits for both supplies, then follows the inputs
    task automatic test_power_up();
        check_lock(1'b1);
        vdd_above_release = 1'b1;
        vdd_below_trip = 1'b0;
        vcc_below_trip = 1'b0;
        gdrv_host_model_inst.set_pins(1'b1, 1'b0, 1'b1);
        hold_gate(1'b0, 30);
        expect_gate(1'b1, 40);
        check_lock(1'b0);
    endtask : test_power_up
    // Short pulses on the pos, neg and run pins leave the gate alone
    task automatic test_glitch();
        gdrv_host_model_inst.set_pins(1'b0, 1'b0, 1'b1);
        gdrv_host_model_inst.set_pins(1'b1, 1'b1, 1'b1);
        gdrv_host_model_inst.set_pins(1'b1, 1'b0, 1'b0);
        gdrv_host_model_inst.set_pins(1'b1, 1'b0, 1'b1);
        hold_gate(1'b1, 12);
        gdrv_host_model_inst.set_pins(1'b1, 1'b0, 1'b0);
        expect_gate(1'b0, 8);
        gdrv_host_model_inst.set_pins(1'b1, 1'b0, 1'b1);
        expect_gate(1'b1, 8);
    endtask : test_glitch
    // Inverting input blocks; idle pins keep the gate low
    task automatic test_inputs();
        gdrv_host_model_inst.set_pins(1'b1, 1'b1, 1'b1);
        expect_gate(1'b0, 8);
        gdrv_host_model_inst.set_pins(1'b0, 1'b0, 1'b1);
        hold_gate(1'b0, 10);
        gdrv_host_model_inst.set_pins(1'b1, 1'b0, 1'b1);
        expect_gate(1'b1, 8);
    endtask : test_inputs
    // Supply dip, lockout, hysteresis and release
    task automatic test_supply();
        vdd_below_trip = 1'b1;
        vdd_above_release = 1'b0;
        cyc(20);
        vdd_below_trip = 1'b0;
        hold_gate(1'b1, 50);
        vdd_below_trip = 1'b1;
        expect_gate(1'b0, 50);
        cyc(2);
        check_lock(1'b1);
        vdd_below_trip = 1'b0;
        hold_gate(1'b0, 60);
        vdd_above_release = 1'b1;
        expect_gate(1'b1, 50);
        cyc(2);
        check_lock(1'b0);
        vcc_below_trip = 1'b1;
        expect_gate(1'b0, 50);
        cyc(2);
        check_lock(1'b1);
    endtask : test_supply
    // Close the run with the verdict
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        reset = 1'b1;
        vcc_below_trip = 1'b1;
        vdd_below_trip = 1'b1;
        vdd_above_release = 1'b0;
        cyc(3);
        reset = 1'b0;
        cyc(1);
        test_power_up();
        test_glitch();
        test_inputs();
        test_supply();
        summarize();
    end
endmodule : gate_driver_input_supply_lockout_gating_tb_top
